// >>> src/lei_pkg.sv
// shared constants and types of the line error insert and irq enable block
package lei_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] LEI_OFS_CTL3 = 8'h00;
    localparam logic [7:0] LEI_OFS_IER = 8'h04;
    localparam logic [7:0] LEI_OFS_ISR = 8'h08;
    localparam logic [7:0] LEI_OFS_STAT = 8'h0C;
    localparam logic [7:0] LEI_OFS_TEST = 8'h10;

    // ==========================================================
    // field positions and masks
    localparam int LEI_IRQ_DMO = 6;
    localparam int LEI_IRQ_FLS = 5;
    localparam int LEI_STAT_LOS = 0;
    localparam int LEI_STAT_DMO = 1;
    localparam int LEI_STAT_NEAR = 2;
    localparam logic [7:0] LEI_IER_WMASK = 8'h60;
    localparam logic [7:0] LEI_CTL3_WMASK = 8'h07;
    localparam logic [7:0] LEI_RST8 = 8'h00;
    localparam logic [31:0] LEI_RD_ZERO = 32'h0000_0000;

    // ==========================================================
    // transmit test pattern
    localparam logic [2:0] LEI_TEST_QRSS = 3'b100;
    localparam logic [2:0] LEI_TEST_RST = 3'b000;
    localparam int LEI_QRSS_LEN = 20;
    localparam int LEI_QRSS_TAP = 17;
    localparam logic [19:0] LEI_QRSS_SEED = 20'hF_FFFF;

    // ==========================================================
    // jitter fifo proximity limit, in bit positions
    localparam int LEI_FIFO_LIMIT = 3;

    // ==========================================================
    // pin synchroniser lanes
    localparam int LEI_PIN_N = 6;
    localparam int LEI_PIN_TCLK = 0;
    localparam int LEI_PIN_TXD = 1;
    localparam int LEI_PIN_LOS = 2;
    localparam int LEI_PIN_DMO = 3;
    localparam int LEI_PIN_RCLK = 4;
    localparam int LEI_PIN_MCLK = 5;

    // ==========================================================
    // types
    typedef struct packed {
        logic pos;
        logic neg;
    } lei_line_t;

    typedef struct packed {
        logic [4:0] unused;
        logic ins_bpv;
        logic ins_ber;
        logic mute;
    } lei_ctl3_t;

endpackage

// >>> src/lei_channel.sv
// per-channel error insertion, rx clock mute and irq enable logic
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Contract
// [RULE_01] each 0-to-1 of the violation control inserts exactly one violation
// [RULE_02] violation insertion works on qrss pattern and on single-rail data
// [RULE_03] both insert controls sampled and edge detected on tx clock rise
// [RULE_04] software writes 0 before 1 to be sure of an insertion
// [RULE_05] 0-to-1 of error control flips one qrss bit, only in qrss mode
// [RULE_06] mute set and signal lost: receive serial clock held still
// [RULE_07] mute clear: receive clock toggles, recovered or master clock
// [RULE_08] drive monitor status change either way raises irq when enabled
// [RULE_09] each enable bit: zero suppresses, one allows its interrupt
// [RULE_10] fifo pointers within three bits raise irq when enabled
// [RULE_11] enable register bit 7 reads zero and ignores writes
// [RULE_12] insert controls resampled in tx clock timing before edge detect
module lei_channel
    import lei_pkg::*;
#(
    parameter int PTR_W = 5
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // transmit line side
    input wire logic channel_transmit_clock_i,
    input wire logic tx_data_i,
    output logic tx_line_pos_o,
    output logic tx_line_neg_o,
    // receive and monitor side
    input wire logic receive_signal_lost_i,
    input wire logic drive_monitor_status_i,
    input wire logic recovered_clock_i,
    input wire logic master_clock_i,
    output logic receive_serial_clock_out_o,
    // jitter attenuator fifo pointers, same clock
    input wire logic [PTR_W-1:0] fifo_wr_ptr_i,
    input wire logic [PTR_W-1:0] fifo_rd_ptr_i
);

    // ==========================================================
    // pin synchronisers
    logic [LEI_PIN_N-1:0] pins;
    logic [LEI_PIN_N-1:0] s1_reg;
    logic [LEI_PIN_N-1:0] s1_next;
    logic [LEI_PIN_N-1:0] s2_reg;
    logic [LEI_PIN_N-1:0] s2_next;

    assign pins[LEI_PIN_TCLK] = channel_transmit_clock_i;
    assign pins[LEI_PIN_TXD] = tx_data_i;
    assign pins[LEI_PIN_LOS] = receive_signal_lost_i;
    assign pins[LEI_PIN_DMO] = drive_monitor_status_i;
    assign pins[LEI_PIN_RCLK] = recovered_clock_i;
    assign pins[LEI_PIN_MCLK] = master_clock_i;

    always_comb begin
        s1_next = pins;
        s2_next = s1_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    logic los_s;
    logic dmo_s;
    assign los_s = s2_reg[LEI_PIN_LOS];
    assign dmo_s = s2_reg[LEI_PIN_DMO];

    // ==========================================================
    // fifo proximity, modulo pointer distance
    logic [PTR_W-1:0] ptr_diff;
    logic fifo_near;
    localparam logic [PTR_W-1:0] LIM = PTR_W'(LEI_FIFO_LIMIT);

    assign ptr_diff = fifo_wr_ptr_i - fifo_rd_ptr_i;
    assign fifo_near = (ptr_diff <= LIM) || (ptr_diff >= -LIM); // [RULE_10]

    // ==========================================================
    // register file, status and interrupt
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    lei_ctl3_t ctl3_reg;
    lei_ctl3_t ctl3_next;
    logic [7:0] ier_reg;
    logic [7:0] ier_next;
    logic [7:0] isr_reg;
    logic [7:0] isr_next;
    logic [2:0] test_reg;
    logic [2:0] test_next;
    logic irq_reg;
    logic irq_next;
    logic dmo_d_reg;
    logic dmo_d_next;
    logic near_d_reg;
    logic near_d_next;
    logic acc;
    logic wr;
    logic rd;

    always_comb begin
        acc = wb_cyc_i && wb_stb_i && !ack_reg;
        wr = acc && wb_we_i && wb_sel_i[0];
        rd = acc && !wb_we_i;
        ack_next = acc;
        dat_next = dat_reg;
        ctl3_next = ctl3_reg;
        ier_next = ier_reg;
        isr_next = isr_reg;
        test_next = test_reg;
        dmo_d_next = dmo_s;
        near_d_next = fifo_near;
        if (wr) begin
            unique case (wb_adr_i)
                LEI_OFS_CTL3: ctl3_next = wb_dat_i[7:0] & LEI_CTL3_WMASK;
                LEI_OFS_IER: ier_next = wb_dat_i[7:0] & LEI_IER_WMASK; // [RULE_11]
                LEI_OFS_TEST: test_next = wb_dat_i[2:0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (wb_adr_i)
                LEI_OFS_CTL3: dat_next = {24'h00_0000, ctl3_reg};
                LEI_OFS_IER: dat_next = {24'h00_0000, ier_reg}; // [RULE_11]
                LEI_OFS_ISR: dat_next = {24'h00_0000, isr_reg};
                LEI_OFS_STAT: begin
                    dat_next = LEI_RD_ZERO;
                    dat_next[LEI_STAT_LOS] = los_s;
                    dat_next[LEI_STAT_DMO] = dmo_s;
                    dat_next[LEI_STAT_NEAR] = fifo_near;
                end
                LEI_OFS_TEST: dat_next = {29'h0000_0000, test_reg};
                default: dat_next = LEI_RD_ZERO;
            endcase
            // read clears status; a same-cycle event below still lands
            if (wb_adr_i == LEI_OFS_ISR) begin
                isr_next = LEI_RST8;
            end
        end
        if (dmo_s != dmo_d_reg) begin
            isr_next[LEI_IRQ_DMO] = 1'b1; // [RULE_08]
        end
        if (fifo_near && !near_d_reg) begin
            isr_next[LEI_IRQ_FLS] = 1'b1; // [RULE_10]
        end
        irq_next = |(isr_next & ier_next); // [RULE_09]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= LEI_RD_ZERO;
            ctl3_reg <= lei_ctl3_t'(LEI_RST8);
            ier_reg <= LEI_RST8;
            isr_reg <= LEI_RST8;
            test_reg <= LEI_TEST_RST;
            irq_reg <= 1'b0;
            dmo_d_reg <= 1'b0;
            near_d_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            ctl3_reg <= ctl3_next;
            ier_reg <= ier_next;
            isr_reg <= isr_next;
            test_reg <= test_next;
            irq_reg <= irq_next;
            dmo_d_reg <= dmo_d_next;
            near_d_reg <= near_d_next;
        end
    end

    // ==========================================================
    // transmit path: qrss source, error insert, ami with violation
    logic tclk_d_reg;
    logic tclk_d_next;
    logic bpv_smp_reg;
    logic bpv_smp_next;
    logic ber_smp_reg;
    logic ber_smp_next;
    logic bpv_pend_reg;
    logic bpv_pend_next;
    logic [LEI_QRSS_LEN-1:0] lfsr_reg;
    logic [LEI_QRSS_LEN-1:0] lfsr_next;
    logic pol_reg;
    logic pol_next;
    lei_line_t line_reg;
    lei_line_t line_next;
    logic tclk_rise;
    logic qrss;
    logic bpv_now;
    logic ber_rise;
    logic tx_bit;

    always_comb begin
        tclk_rise = s2_reg[LEI_PIN_TCLK] && !tclk_d_reg;
        qrss = (test_reg == LEI_TEST_QRSS);
        tclk_d_next = s2_reg[LEI_PIN_TCLK];
        bpv_smp_next = bpv_smp_reg;
        ber_smp_next = ber_smp_reg;
        bpv_pend_next = bpv_pend_reg;
        lfsr_next = lfsr_reg;
        pol_next = pol_reg;
        line_next = line_reg;
        bpv_now = bpv_pend_reg;
        ber_rise = 1'b0;
        tx_bit = 1'b0;
        // controls are looked at only on tx clock rises, so a write
        // shorter than one line bit may be missed entirely
        if (tclk_rise) begin
            bpv_smp_next = ctl3_reg.ins_bpv; // [RULE_03] [RULE_12]
            ber_smp_next = ctl3_reg.ins_ber; // [RULE_03] [RULE_12]
            bpv_now = bpv_pend_reg
                || (ctl3_reg.ins_bpv && !bpv_smp_reg); // [RULE_01]
            ber_rise = ctl3_reg.ins_ber && !ber_smp_reg;
            if (qrss) begin
                lfsr_next = {lfsr_reg[LEI_QRSS_LEN-2:0],
                    lfsr_reg[LEI_QRSS_LEN-1] ^ lfsr_reg[LEI_QRSS_TAP-1]};
                tx_bit = lfsr_reg[LEI_QRSS_LEN-1] ^ ber_rise; // [RULE_05]
            end else begin
                tx_bit = s2_reg[LEI_PIN_TXD]; // [RULE_02]
            end
            // violation waits for the next mark: a space has no polarity
            if (tx_bit) begin
                if (!bpv_now) begin
                    pol_next = !pol_reg;
                end
                bpv_pend_next = 1'b0; // [RULE_01] [RULE_02]
            end else begin
                bpv_pend_next = bpv_now;
            end
            line_next.pos = tx_bit && pol_next;
            line_next.neg = tx_bit && !pol_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tclk_d_reg <= 1'b0;
            bpv_smp_reg <= 1'b0;
            ber_smp_reg <= 1'b0;
            bpv_pend_reg <= 1'b0;
            lfsr_reg <= LEI_QRSS_SEED;
            pol_reg <= 1'b0;
            line_reg <= '0;
        end else begin
            tclk_d_reg <= tclk_d_next;
            bpv_smp_reg <= bpv_smp_next;
            ber_smp_reg <= ber_smp_next;
            bpv_pend_reg <= bpv_pend_next;
            lfsr_reg <= lfsr_next;
            pol_reg <= pol_next;
            line_reg <= line_next;
        end
    end

    // ==========================================================
    // receive serial clock select and mute
    logic rxclk_reg;
    logic rxclk_next;

    always_comb begin
        if (ctl3_reg.mute && los_s) begin
            rxclk_next = 1'b0; // [RULE_06]
        end else if (los_s) begin
            rxclk_next = s2_reg[LEI_PIN_MCLK]; // [RULE_07]
        end else begin
            rxclk_next = s2_reg[LEI_PIN_RCLK]; // [RULE_07]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxclk_reg <= 1'b0;
        end else begin
            rxclk_reg <= rxclk_next;
        end
    end

    // ==========================================================
    // outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign tx_line_pos_o = line_reg.pos;
    assign tx_line_neg_o = line_reg.neg;
    assign receive_serial_clock_out_o = rxclk_reg;

endmodule

// >>> sim/lei_channel_monitor.sv
// checker of bus, line and receive clock behaviour of one channel
`timescale 1ns/1ps
module lei_channel_monitor
    import lei_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // line and clocks
    input wire logic channel_transmit_clock_i,
    input wire logic tx_line_pos_o,
    input wire logic tx_line_neg_o,
    input wire logic receive_signal_lost_i,
    input wire logic recovered_clock_i,
    input wire logic master_clock_i,
    input wire logic receive_serial_clock_out_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ==========
    // register bus
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not answered");
    ack_cause_a: assert property (wb_ack_o
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    ier_bit7_a: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == LEI_OFS_IER)
        |-> !wb_dat_o[7]) else $error("enable bit 7 reads one");

    // ==========
    // line: only one rail at a time, changes only after a tx clock rise
    line_excl_a: assert property (
        !(tx_line_pos_o && tx_line_neg_o)) else $error("both rails high");
    line_hold_a: assert property (
        !channel_transmit_clock_i [*7]
        |-> $stable(tx_line_pos_o) && $stable(tx_line_neg_o))
        else $error("line moved without tx clock rise");

    // ==========
    // receive clock: two sync flops plus output flop, three cycles
    rx_follow_a: assert property (
        !receive_signal_lost_i [*5]
        |-> receive_serial_clock_out_o == $past(recovered_clock_i, 3))
        else $error("rx clock not recovered clock");
    rx_lost_a: assert property (
        receive_signal_lost_i [*5] |-> !receive_serial_clock_out_o
        || receive_serial_clock_out_o == $past(master_clock_i, 3))
        else $error("rx clock neither muted nor master");
endmodule

bind lei_channel lei_channel_monitor mon_u (.*);

// >>> sim/lei_line_partner.sv
// remote line end: clocks toward the channel, mark checker on the tx line
`timescale 1ns/1ps
module lei_line_partner
    import lei_pkg::*;
(
    // line from the channel
    input wire logic line_pos_i,
    input wire logic line_neg_i,
    // clocks toward the channel
    output logic tx_clk_o,
    output logic rec_clk_o,
    output logic mst_clk_o,
    // marks that repeated the previous polarity
    output int viol_o,
    // received bits that break the test pattern recurrence
    output int qerr_o,
    // spaces seen on the line
    output int space_o
);
    logic last_pos;
    logic mark;
    logic [LEI_QRSS_LEN-1:0] hist;

    assign mark = line_pos_i || line_neg_i;

    initial begin
        tx_clk_o = 0;
        rec_clk_o = 0;
        mst_clk_o = 0;
        viol_o = 0;
        qerr_o = 0;
        space_o = 0;
        last_pos = 0;
        hist = '0;
    end

    // edges land half a system period off its rising edge, so no race
    always #64 tx_clk_o = ~tx_clk_o;
    always #24 rec_clk_o = ~rec_clk_o;
    always #32 mst_clk_o = ~mst_clk_o;

    // sampled mid-bit; spaces carry no polarity
    always @(negedge tx_clk_o) begin
        if (line_pos_i || line_neg_i) begin
            if (line_pos_i == last_pos) viol_o <= viol_o + 1;
            last_pos <= line_pos_i;
        end else begin
            space_o <= space_o + 1;
        end
        // a single flipped bit breaks the recurrence exactly three times
        if (mark != (hist[LEI_QRSS_LEN-1] ^ hist[LEI_QRSS_TAP-1])) begin
            qerr_o <= qerr_o + 1;
        end
        hist <= {hist[LEI_QRSS_LEN-2:0], mark};
    end
endmodule

// >>> sim/tb.sv
// testbench of the channel: registers, insertion, rx clock, interrupts
`timescale 1ns/1ps
module tb;
    import lei_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic wb_ack_o, irq_o, tx_line_pos_o, tx_line_neg_o, tx_data_i = 1;
    logic channel_transmit_clock_i, recovered_clock_i, master_clock_i;
    logic receive_signal_lost_i = 0, drive_monitor_status_i = 0;
    logic receive_serial_clock_out_o;
    logic [4:0] fifo_wr_ptr_i = 5'h10, fifo_rd_ptr_i = 5'h00;
    int fails = 0, num_checks = 0, viol, t;
    int qerr, spaces, e0;

    always #4 clk_i = ~clk_i;
    lei_channel dut_u (.*);
    lei_line_partner far_u (.line_pos_i(tx_line_pos_o),
        .line_neg_i(tx_line_neg_o), .tx_clk_o(channel_transmit_clock_i),
        .rec_clk_o(recovered_clock_i), .mst_clk_o(master_clock_i),
        .viol_o(viol), .qerr_o(qerr), .space_o(spaces));

    // ==========
    // shared tasks
    task summarize;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fails++;
            summarize();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wirq(input logic v);
        for (int n = 0; n < 20 && irq_o !== v; n++) @(posedge clk_i);
        chk(irq_o, v);
        if (irq_o !== v) summarize();
    endtask
    task hi;
        repeat (6) @(posedge clk_i);
        t = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (receive_serial_clock_out_o === 1'b1) t++;
        end
    endtask

    // ==========
    // scenarios
    task regs_t;
        wb(0, LEI_OFS_IER, 0);
        chk(q, 32'h0000_0000);
        wb(1, LEI_OFS_IER, 32'hFFFF_FFFF);
        wb(0, LEI_OFS_IER, 0);
        chk(q, 32'h0000_0060);
        wb(0, 8'h14, 0);
        chk(q, 32'h0000_0000);
        wb(1, LEI_OFS_IER, 0);
    endtask
    task bpv_t;
        // third pass runs on the test pattern instead of line data;
        // on line data the error control rides along and must do nothing
        for (int i = 1; i <= 3; i++) begin
            if (i == 3) wb(1, LEI_OFS_TEST, 32'h0000_0004);
            wb(1, LEI_OFS_CTL3, 0);
            repeat (40) @(posedge clk_i);
            wb(1, LEI_OFS_CTL3, i < 3 ? 32'h0000_0006 : 32'h0000_0004);
            repeat (100) @(posedge clk_i);
            chk(viol, i);
            if (i == 2) chk(spaces, 0);
        end
        // long waits: the far end needs a full pattern length of history
        wb(1, LEI_OFS_CTL3, 0);
        repeat (400) @(posedge clk_i);
        e0 = qerr;
        wb(1, LEI_OFS_CTL3, 32'h0000_0002);
        repeat (400) @(posedge clk_i);
        chk(viol, 3);
        chk(qerr - e0, 3);
        wb(1, LEI_OFS_TEST, 0);
        wb(1, LEI_OFS_CTL3, 0);
    endtask
    task mute_t;
        for (int m = 1; m >= 0; m--) begin
            wb(1, LEI_OFS_CTL3, 32'(m));
            receive_signal_lost_i <= 1'b1;
            hi();
            chk(t == 0, m);
        end
        receive_signal_lost_i <= 1'b0;
        hi();
        chk(t > 0 && t < 40, 1);
    endtask
    task dmo_t;
        wb(1, LEI_OFS_IER, 32'h0000_0040);
        wb(0, LEI_OFS_ISR, 0);
        for (int v = 1; v >= 0; v--) begin
            drive_monitor_status_i <= v[0];
            wirq(1'b1);
            wb(0, LEI_OFS_ISR, 0);
            chk(q & 32'h0000_0040, 32'h0000_0040);
            wirq(1'b0);
        end
        wb(1, LEI_OFS_IER, 0);
        drive_monitor_status_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(irq_o, 0);
        wb(1, LEI_OFS_IER, 32'h0000_0040);
        wirq(1'b1);
        wb(0, LEI_OFS_ISR, 0);
        wirq(1'b0);
    endtask
    task fifo_t;
        wb(1, LEI_OFS_IER, 32'h0000_0020);
        fifo_rd_ptr_i <= 5'h0C;
        repeat (10) @(posedge clk_i);
        chk(irq_o, 0);
        fifo_rd_ptr_i <= 5'h0D;
        wirq(1'b1);
        wb(0, LEI_OFS_ISR, 0);
        chk(q & 32'h0000_0020, 32'h0000_0020);
        // read pointer ahead of write pointer: four apart, then three
        fifo_rd_ptr_i <= 5'h14;
        repeat (10) @(posedge clk_i);
        chk(irq_o, 0);
        fifo_rd_ptr_i <= 5'h13;
        wirq(1'b1);
        wb(0, LEI_OFS_ISR, 0);
        chk(q & 32'h0000_0020, 32'h0000_0020);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_t();
        bpv_t();
        mute_t();
        dmo_t();
        fifo_t();
        summarize();
    end
endmodule
